// ==== core/sac_pkg.sv ====
// Purpose: Shared constants and carriers for the converter control block.
// Assumes: 8-bit register port, one clock, analog core outside.
// Notes:   Offsets are register indices on the plain register port.
`default_nettype none
package sac_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [2:0] SAC_OFF_SELECT = 3'h0; // conv_select_register
  localparam logic [2:0] SAC_OFF_CTRL_A = 3'h1; // conv_ctrl_status_a
  localparam logic [2:0] SAC_OFF_CTRL_B = 3'h2; // conv_ctrl_status_b
  localparam logic [2:0] SAC_OFF_RES_LO = 3'h3; // result_low_byte
  localparam logic [2:0] SAC_OFF_RES_HI = 3'h4; // result_high_byte
  localparam logic [2:0] SAC_OFF_MISC   = 3'h5; // analog_misc_control

  // ==========================================================
  // Field positions
  localparam int SAC_SEL_REF_LSB   = 6; // reference_select [7:6]
  localparam int SAC_SEL_LEFT      = 5; // left_adjust_result
  localparam int SAC_CA_ENABLE     = 7; // converter_enable
  localparam int SAC_CA_START      = 6; // start_conversion
  localparam int SAC_CA_AUTO       = 5; // auto_trigger_enable
  localparam int SAC_CA_FLAG       = 4; // conversion_complete_flag
  localparam int SAC_CA_IE         = 3; // complete interrupt enable
  localparam int SAC_MISC_CURRENT_SOURCE_CHANNEL     = 0; // current_source_enable
  localparam int SAC_MISC_EXTREF   = 1; // external_ref_input_enable
  localparam int SAC_MISC_REFPIN   = 2; // ref_pin_output_enable

  // ==========================================================
  // Reset values
  localparam logic [7:0] SAC_RST_SELECT = 8'h00;
  localparam logic [7:0] SAC_RST_CTRL   = 8'h00;
  localparam logic [2:0] SAC_RST_TRIG   = 3'h0;
  localparam logic [2:0] SAC_RST_MISC   = 3'h0;

  // ==========================================================
  // Timing counts, in converter clock ticks
  localparam logic [4:0] SAC_CONV_NORMAL = 5'd13;
  localparam logic [4:0] SAC_CONV_FIRST  = 5'd25;
  localparam logic [2:0] SAC_TRIG_FREE   = 3'h0; // source 0: own flag

  // Reference modes driven to the analog core
  typedef enum logic [1:0] {SAC_REF_SUPPLY, SAC_REF_EXT_PIN, SAC_REF_INT_LOW,
                            SAC_REF_INT_HIGH} sac_ref_e;

  // Analog core controls
  typedef struct packed {
    logic       conv_power;
    sac_ref_e   ref_mode;
    logic       ref_pin_output_enable;
    logic       external_ref_input_enable;
    logic       current_source_on;
    logic [4:0] channel;
    logic       diff_path;
    logic       gain_20x;
    logic       sample_hold;
    logic [9:0] dac_code;
  } sac_ana_s;
endpackage
`default_nettype wire

// ==== core/sac_ctrl.sv ====
// Purpose: Register file, sequencing and successive approximation control
//          for a 10-bit converter with auto trigger and result lock.
// Assumes: Inputs synchronous to clk; comparator answers within one clock.
// Notes:   Read data stand one cycle after the read strobe.
//
// The register offsets and strobed register access were left to the implementer.
`default_nettype none
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int TRIG_N = 8
)(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // Register port
  input  wire logic [2:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output var  logic [7:0]    reg_rdata,
  // Trigger sources and comparator
  input  wire logic [TRIG_N-1:0] trig_in,
  input  wire logic          comp_above,
  // Analog core controls and interrupt request
  output var  sac_pkg::sac_ana_s ana,
  output var  logic          irq
);
  import sac_pkg::*;

  // ==========================================================
  // Elaboration check
  if (TRIG_N < 2 || TRIG_N > 8)
  begin : g_chk
    $error("TRIG_N must be 2 to 8");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] sel_raw;
    logic       enable;
    logic       auto_trig;
    logic       flag;
    logic       ie;
    logic [2:0] ps;
    logic [2:0] trig_sel;
    logic [2:0] misc;
    logic [9:0] res;
    logic       lock;
    logic       pend;
    logic       busy;
    logic       first;
    logic [7:0] presc;
    logic [4:0] cnt;
    logic [3:0] idx;
    logic       trig_prev;
    logic [1:0] act_ref;
    logic [4:0] act_ch;
    logic       act_left;
    logic [7:0] rdata;
    logic       irq;
    sac_ana_s   ana;
  } sac_state_s;

  sac_state_s st_q;
  sac_state_s st_d;

  // ==========================================================
  // Functions
  // Prescaler wraps at 2^(ps+1)-1; ps of zero divides by two
  function automatic logic [7:0] presc_top(input logic [2:0] ps);
    presc_top = 8'(({1'b0, 8'hFF}) >> (3'd7 - ps));
  endfunction

  // Ticks in a conversion
  function automatic logic [4:0] conv_len(input logic first);
    conv_len = first ? SAC_CONV_FIRST : SAC_CONV_NORMAL;
  endfunction

  // Alignment of the stored code into the two bytes
  function automatic logic [15:0] align(input logic [9:0] r, input logic left);
    align = left ? {r, 6'h00} : {6'h00, r};
  endfunction

  // Reference decode from select field
  function automatic sac_ref_e ref_dec(input logic [1:0] reference_select);
    ref_dec = sac_ref_e'(reference_select);
  endfunction

  // ==========================================================
  // Combinational helpers
  logic       tick;
  logic       done;
  logic       trig_lvl;
  logic       trig_rise;
  logic       wr_a;
  logic       rd_lo;
  logic       rd_hi;
  logic [4:0] base;
  logic [15:0] view;

  always_comb
  begin
    tick      = st_q.enable && (st_q.presc == presc_top(st_q.ps));
    base      = conv_len(st_q.first) - SAC_CONV_NORMAL;
    done      = st_q.busy && tick && (st_q.cnt == conv_len(st_q.first) - 5'd1);
    // Compare one bit wider, TRIG_N of 8 does not fit the select field
    trig_lvl  = ({1'b0, st_q.trig_sel} < 4'(TRIG_N)) ? trig_in[st_q.trig_sel] : 1'b0;
    trig_rise = trig_lvl && !st_q.trig_prev;
    wr_a      = reg_wr && (reg_addr == SAC_OFF_CTRL_A);
    rd_lo     = reg_rd && (reg_addr == SAC_OFF_RES_LO);
    rd_hi     = reg_rd && (reg_addr == SAC_OFF_RES_HI);
    view      = align(st_q.res, st_q.act_left);
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    st_d = st_q;
    st_d.trig_prev = trig_lvl;

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        SAC_OFF_SELECT: st_d.sel_raw = reg_wdata;
        SAC_OFF_CTRL_A:
        begin
          st_d.enable    = reg_wdata[SAC_CA_ENABLE];
          st_d.auto_trig = reg_wdata[SAC_CA_AUTO];
          st_d.ie        = reg_wdata[SAC_CA_IE];
          st_d.ps        = reg_wdata[2:0];
          // Write one clears the flag
          if (reg_wdata[SAC_CA_FLAG])
            st_d.flag = 1'b0;
        end
        SAC_OFF_CTRL_B: st_d.trig_sel = reg_wdata[2:0];
        SAC_OFF_MISC:   st_d.misc = reg_wdata[2:0];
        default: ;
      endcase
    end

    // Prescaler, held at zero while disabled
    if (!st_q.enable || tick)
      st_d.presc = 8'h00;
    else
      st_d.presc = st_q.presc + 8'h01;

    // Software start: zero or start while active does nothing
    if (wr_a && reg_wdata[SAC_CA_START] && reg_wdata[SAC_CA_ENABLE] && st_q.enable
        && !st_q.busy && !st_q.pend)
      st_d.pend = 1'b1;

    // Edge trigger, only when idle; levels and busy-time edges do nothing
    if (st_q.auto_trig && st_q.enable && st_q.trig_sel != SAC_TRIG_FREE
        && trig_rise && !st_q.busy && !st_q.pend)
    begin
      st_d.pend  = 1'b1;
      st_d.presc = 8'h00;
    end

    // Launch on the next converter tick
    if (st_q.pend && tick)
    begin
      st_d.pend = 1'b0;
      st_d.busy = 1'b1;
      st_d.cnt  = 5'd0;
    end

    // Conversion sequence
    if (st_q.busy && tick && !done)
    begin
      st_d.cnt = st_q.cnt + 5'd1;
      // Sample window ends, first trial bit
      if (st_q.cnt == base + 5'd1)
      begin
        st_d.ana.sample_hold = 1'b0;
        st_d.ana.dac_code    = 10'h200;
        st_d.idx             = 4'd9;
      end
      // One decision per tick, most significant first
      else if (st_q.cnt >= base + 5'd2 && st_q.cnt <= base + 5'd11)
      begin
        if (!comp_above)
          st_d.ana.dac_code[st_q.idx] = 1'b0;
        if (st_q.idx != 4'd0)
        begin
          st_d.ana.dac_code[st_q.idx - 4'd1] = 1'b1;
          st_d.idx = st_q.idx - 4'd1;
        end
      end
    end

    // Completion
    if (done)
    begin
      st_d.flag  = 1'b1;
      st_d.first = 1'b0;
      st_d.busy  = 1'b0;
      // Locked result registers drop the code unless the high byte is read in this cycle, a low read in this cycle locks too
      if ((!st_q.lock && !rd_lo) || rd_hi)
      begin
        st_d.res      = st_q.ana.dac_code;
        st_d.act_left = st_q.sel_raw[SAC_SEL_LEFT];
      end
      // Flag as source keeps converting whether cleared or not
      if (st_q.auto_trig && st_q.trig_sel == SAC_TRIG_FREE)
      begin
        st_d.busy = 1'b1;
        st_d.cnt  = 5'd0;
      end
    end

    // Sample phase marker at conversion start
    if ((st_q.pend && tick) || (done && st_d.busy))
      st_d.ana.sample_hold = 1'b1;

    // Result lock by byte reads
    if (rd_lo)
      st_d.lock = 1'b1;
    if (rd_hi)
      st_d.lock = 1'b0;

    // Selection follows the register only between conversions
    if (st_q.enable && !st_q.busy && !st_q.pend)
    begin
      st_d.act_ref = st_q.sel_raw[SAC_SEL_REF_LSB +: 2];
      st_d.act_ch  = st_q.sel_raw[4:0];
    end
    if (st_q.enable && !st_q.busy)
      st_d.act_left = st_q.sel_raw[SAC_SEL_LEFT];

    // Disable aborts; next enable gives a long first conversion
    if (!st_q.enable)
    begin
      st_d.busy  = 1'b0;
      st_d.pend  = 1'b0;
      st_d.first = 1'b1;
      st_d.ana.sample_hold = 1'b0;
    end

    // Analog controls
    st_d.ana.conv_power = st_q.enable;
    st_d.ana.ref_mode   = ref_dec(st_q.act_ref);
    st_d.ana.ref_pin_output_enable = st_q.misc[SAC_MISC_REFPIN]
                                     && st_q.act_ref[1] && st_q.enable;
    st_d.ana.external_ref_input_enable = st_q.misc[SAC_MISC_EXTREF];
    st_d.ana.current_source_on = st_q.misc[SAC_MISC_CURRENT_SOURCE_CHANNEL];
    st_d.ana.channel   = st_q.act_ch;
    st_d.ana.diff_path = st_q.act_ch[4];
    st_d.ana.gain_20x  = st_q.act_ch[4] && st_q.act_ch[3];

    st_d.irq = st_q.flag && st_q.ie;

    // Read data, one cycle after the strobe
    st_d.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        SAC_OFF_SELECT: st_d.rdata = st_q.sel_raw;
        SAC_OFF_CTRL_A: st_d.rdata = {st_q.enable, st_q.pend || st_q.busy,
                                      st_q.auto_trig, st_q.flag, st_q.ie,
                                      st_q.ps};
        SAC_OFF_CTRL_B: st_d.rdata = {5'h00, st_q.trig_sel};
        SAC_OFF_RES_LO: st_d.rdata = view[7:0];
        SAC_OFF_RES_HI: st_d.rdata = view[15:8];
        SAC_OFF_MISC:   st_d.rdata = {5'h00, st_q.misc};
        default:        st_d.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= '0;
      st_q.sel_raw  <= SAC_RST_SELECT;
      st_q.trig_sel <= SAC_RST_TRIG;
      st_q.misc     <= SAC_RST_MISC;
      st_q.first    <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  // Outputs straight from the state register
  assign reg_rdata = st_q.rdata;
  assign ana       = st_q.ana;
  assign irq       = st_q.irq;

  // ==========================================================
  // Assertions
  current_source_channel_follow_a: assert property (@(posedge clk) disable iff (!resetn)
    (reg_wr && reg_addr == SAC_OFF_MISC) |-> ##2
      (ana.current_source_on == $past(reg_wdata[SAC_MISC_CURRENT_SOURCE_CHANNEL], 2)))
    else $error("current source does not follow misc bit");

  lock_blocks_a: assert property (@(posedge clk) disable iff (!resetn)
    (done && (st_q.lock || rd_lo) && !rd_hi) |=> $stable(st_q.res))
    else $error("locked result was overwritten");

  unlock_read_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_hi |=> !st_q.lock)
    else $error("high byte read left result locked");

  flag_on_done_a: assert property (@(posedge clk) disable iff (!resetn)
    done |=> st_q.flag ##1 (irq == $past(st_q.ie)))
    else $error("completion did not set flag");

  chan_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q.busy |=> $stable(st_q.act_ch))
    else $error("channel changed during conversion");

  trig_arm_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q.auto_trig && st_q.enable && st_q.trig_sel != SAC_TRIG_FREE && trig_rise
     && !st_q.busy && !st_q.pend) |=> st_q.pend && st_q.presc == 8'h00)
    else $error("trigger edge did not arm a conversion");

  conv_length_a: assert property (@(posedge clk) disable iff (!resetn)
    done |-> (st_q.first ? (st_q.cnt == 5'd24) : (st_q.cnt == 5'd12)))
    else $error("conversion length wrong");

  presc_held_a: assert property (@(posedge clk) disable iff (!resetn)
    !st_q.enable |=> (st_q.presc == 8'h00) && !st_q.busy && !st_q.pend)
    else $error("prescaler or conversion active while disabled");

  edge_ignored_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q.busy && !done) |=> !st_q.pend)
    else $error("start accepted during conversion");

  free_run_a: assert property (@(posedge clk) disable iff (!resetn)
    (done && st_q.enable && st_q.auto_trig && st_q.trig_sel == SAC_TRIG_FREE
     && !wr_a) |=> st_q.busy && st_q.cnt == 5'd0)
    else $error("free running restart missing");

  start_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    (done && !st_q.auto_trig && !wr_a) |=> !st_q.busy && !st_q.pend)
    else $error("start bit not cleared at completion");

  zero_start_a: assert property (@(posedge clk) disable iff (!resetn)
    (wr_a && !reg_wdata[SAC_CA_START] && !st_q.pend && !st_q.auto_trig)
      |=> !st_q.pend)
    else $error("zero write started a conversion");
endmodule
`default_nettype wire

// ==== sim/sac_ana_model.sv ====
// Purpose: Comparator stand-in for the analog core.
// Assumes: Input level is a static code set by the bench.
// Notes:   Unpowered core answers with a toggle, never a held value.
`default_nettype none
module sac_ana_model
  import sac_pkg::*;
(
  // Clock and core controls
  input  wire logic              clk,
  input  wire sac_pkg::sac_ana_s ana,
  input  wire logic [9:0]        level,
  // Comparator answer
  output var  logic              comp_above
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog_q = 1'b0;
  // ==========================================================
  // Toggle so a dead core cannot pass for a valid answer
  always_ff @(posedge clk) tog_q <= ~tog_q;
  // Input at or above the trial code
  assign comp_above = ana.conv_power ? (level >= ana.dac_code) : tog_q;
endmodule
`default_nettype wire

// ==== sim/sar_adc_conversion_control_tb_top.sv ====
// Purpose: Self-checking bench for the converter control block.
// Assumes: Prescaler 0, so one converter tick is two clocks.
// Notes:   Completion times are windows around the tick counts.
`default_nettype none
module sar_adc_conversion_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sac_pkg::*;
  // ==========================================================
  // Design ports
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] trig_in = 8'h00;
  logic       comp_above;
  sac_ana_s   ana;
  logic       irq;
  logic [9:0] level = 10'h000;
  int         n_errors = 0;
  int         check_count = 0;
  int         cyc = 0;

  sac_ctrl #(.TRIG_N(8)) DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trig_in(trig_in), .comp_above(comp_above), .ana(ana), .irq(irq));
  sac_ana_model ANA (.clk(clk), .ana(ana), .level(level), .comp_above(comp_above));

  initial forever #5 clk = ~clk;

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end

  task complete_run;
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Bus and compare helpers
  task ck(input logic [9:0] got, input logic [9:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task rd(input logic [2:0] a, output logic [9:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = {2'h0, reg_rdata};
  endtask

  // Outputs trail state by a cycle, so allow a margin
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task wirq(input int lo, input int hi);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1 n++;
    end
    ck(10'(n >= lo && n <= hi), 10'h001, "completion time");
  endtask

  task conv(input logic [7:0] cmd, input int lo, input logic busy_end);
    logic [9:0] d;
    wr(SAC_OFF_CTRL_A, cmd);
    rd(SAC_OFF_CTRL_A, d);
    ck({9'h0, d[6]}, 10'h001, "busy readback");
    ck(10'(ana.sample_hold), 10'h001, "sampling at start");
    wirq(lo, lo + 10);
    rd(SAC_OFF_CTRL_A, d);
    ck({9'h0, d[6]}, {9'h0, busy_end}, "start bit at end");
    ck({9'h0, d[4]}, 10'h001, "complete flag");
    wr(SAC_OFF_CTRL_A, (cmd & 8'hBF) | 8'h10);
  endtask

  // Low byte first keeps both bytes from one conversion
  task res(input logic [9:0] lo_e, input logic [9:0] hi_e);
    logic [9:0] d;
    rd(SAC_OFF_RES_LO, d);
    ck(d, lo_e, "result low");
    rd(SAC_OFF_RES_HI, d);
    ck(d, hi_e, "result high");
  endtask

  // ==========================================================
  // Scenarios
  task t_regs;
    logic [9:0] d;
    for (int i = 0; i < 8; i++)
    begin
      rd(3'(i), d);
      ck(d, 10'h000, "reset value");
    end
    wr(SAC_OFF_MISC, 8'hFF);
    rd(SAC_OFF_MISC, d);
    ck(d, 10'h007, "misc readback");
    settle();
    ck(10'(ana.current_source_on), 10'h001, "source on");
    ck(10'(ana.external_ref_input_enable), 10'h001, "ext ref input");
    ck(10'(ana.ref_pin_output_enable), 10'h000, "ref pin while off");
    wr(SAC_OFF_MISC, 8'h04);
    settle();
    ck(10'(ana.current_source_on), 10'h000, "source off");
  endtask

  task t_gate;
    logic [9:0] d;
    wr(SAC_OFF_SELECT, 8'hDB);
    wr(SAC_OFF_CTRL_A, 8'h40);
    settle();
    ck(10'(ana.conv_power), 10'h000, "power off");
    ck(10'(ana.channel), 10'h000, "channel held off");
    rd(SAC_OFF_CTRL_A, d);
    ck(d, 10'h000, "start refused");
    wr(SAC_OFF_CTRL_A, 8'h88);
    settle();
    ck(10'(ana.ref_mode), 10'h003, "reference mode");
    ck(10'(ana.ref_pin_output_enable), 10'h001, "ref pin");
    ck(10'(ana.channel), 10'h01B, "channel");
    ck(10'({ana.diff_path, ana.gain_20x}), 10'h003, "gain 20x");
    wr(SAC_OFF_SELECT, 8'h13);
    settle();
    ck(10'({ana.diff_path, ana.gain_20x}), 10'h002, "gain 8x");
    wr(SAC_OFF_SELECT, 8'h05);
    settle();
    ck(10'({ana.diff_path, ana.gain_20x}), 10'h000, "bypass");
  endtask

  task t_conv;
    logic [9:0] d;
    level = 10'h2A5;
    conv(8'hC8, 44, 1'b0);
    res(10'h0A5, 10'h002);
    wr(SAC_OFF_SELECT, 8'h25);
    level = 10'h3C7;
    conv(8'hC8, 20, 1'b0);
    rd(SAC_OFF_RES_LO, d);
    ck(d, 10'h0C0, "left low");
    level = 10'h155;
    conv(8'hC8, 20, 1'b0);
    rd(SAC_OFF_RES_HI, d);
    ck(d, 10'h0F1, "locked high");
    conv(8'hC8, 20, 1'b0);
    res(10'h040, 10'h055);
  endtask

  task t_chan;
    wr(SAC_OFF_SELECT, 8'h05);
    wr(SAC_OFF_CTRL_A, 8'hC8);
    repeat (4) @(posedge clk);
    wr(SAC_OFF_SELECT, 8'h07);
    settle();
    ck(10'(ana.channel), 10'h005, "old channel kept");
    ck(10'(ana.sample_hold), 10'h000, "sample window closed");
    wirq(10, 26);
    settle();
    ck(10'(ana.channel), 10'h007, "new channel");
    wr(SAC_OFF_CTRL_A, 8'h98);
  endtask

  task t_auto;
    wr(SAC_OFF_CTRL_B, 8'h03);
    wr(SAC_OFF_CTRL_A, 8'hA8);
    trig_in[3] <= 1'b1;
    wirq(22, 34);
    wr(SAC_OFF_CTRL_A, 8'hB8);
    repeat (60) @(posedge clk);
    #1 ck(10'(irq), 10'h000, "level retrigger");
    trig_in[3] <= 1'b0;
    @(posedge clk);
    trig_in[3] <= 1'b1;
    repeat (8) @(posedge clk);
    trig_in[3] <= 1'b0;
    repeat (2) @(posedge clk);
    trig_in[3] <= 1'b1;
    wirq(8, 24);
    wr(SAC_OFF_CTRL_A, 8'hB8);
    repeat (60) @(posedge clk);
    #1 ck(10'(irq), 10'h000, "edge in conversion");
    conv(8'hE8, 20, 1'b0);
  endtask

  task t_free;
    logic [9:0] d;
    wr(SAC_OFF_CTRL_B, 8'h00);
    conv(8'hE8, 20, 1'b1);
    // Interrupt line lags the flag clear, let it drop first
    settle();
    wirq(14, 30);
    // Disable and clear the flag in one write
    wr(SAC_OFF_CTRL_A, 8'h10);
    settle();
    rd(SAC_OFF_CTRL_A, d);
    ck(d, 10'h000, "disable stops");
    ck(10'(ana.conv_power), 10'h000, "power off again");
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_gate();
    t_conv();
    t_chan();
    t_auto();
    t_free();
    complete_run();
  end
endmodule
`default_nettype wire
